// ==== verilog/cts_pkg.sv ====
// Package for the capture 0 trigger selector: offsets, field layout, widths
package cts_pkg;
    // ****************************************
    // Register map
    // ****************************************
    localparam logic [7:0]  CTS_ADDR_TRIG_SEL  = 8'h5C;
    localparam logic [31:0] CTS_TRIG_SEL_RESET = 32'h0000_0000;
    localparam logic [31:0] CTS_RDATA_NONE     = 32'h0000_0000;
    // ****************************************
    // Field layout
    // ****************************************
    localparam int CTS_BIT_SOFT      = 0;
    localparam int CTS_BIT_UPDATE    = 1;
    localparam int CTS_BIT_EXT_LO    = 2;
    localparam int CTS_NUM_EXT       = 10;
    localparam int CTS_SUB_BASE      = 12;
    localparam int CTS_SUB_GROUP     = 4;
    localparam int CTS_NUM_SUB       = 5;
    // Position inside one sibling group
    localparam int CTS_OFS_RISE      = 0;
    localparam int CTS_OFS_FALL      = 1;
    localparam int CTS_OFS_CMP0      = 2;
    localparam int CTS_OFS_CMP1      = 3;
    localparam logic [3:0] CTS_GROUP_ZERO = 4'h0;
endpackage

// ==== verilog/cts_capture0_trigger_select.sv ====
// Capture 0 trigger-source selector of one sub-timer
//
// Added by the designer: the plain strobed port.
`timescale 1ns/10ps
`default_nettype none

// Notes on behaviour
// - The select register sits at 0x5C, resets to zero and is used as a full word.
// - Bits 2 to 11 each let one of external events 0 to 9 fire capture 0.
// - Bit 1 lets every update event fire capture 0, and clear it does not.
// - Writing one to bit 0 fires capture 0 at once and hardware clears the bit.
// - A set compare-1 enable of a sibling lets its compare 1 event fire capture 0.
// - A set compare-0 enable of a sibling lets its compare 0 event fire capture 0.
// - A set falling enable fires capture 0 when the sibling output goes inactive.
// - A set rising enable fires capture 0 when the sibling output goes active.
// - Sibling groups run compare 1, compare 0, fall, rise from the high bit, 4 at 31:28.
// - The group that names this instance itself is reserved and reads zero.
module cts_capture0_trigger_select
    import cts_pkg::*;
#(
    parameter int SELF_INDEX = 0
)
(
    // Clock, reset, enable
    input  wire logic                   ref_clk_i,
    input  wire logic                   rst_n_i,
    input  wire logic                   clk_en_i,
    // Register port
    input  wire logic [7:0]             reg_addr_i,
    input  wire logic [31:0]            reg_wdata_i,
    input  wire logic                   reg_wr_i,
    input  wire logic                   reg_rd_i,
    output var  logic [31:0]            reg_rdata_o,
    // Event sources, same clock
    input  wire logic [CTS_NUM_EXT-1:0] ext_event_i,
    input  wire logic                   update_event_i,
    input  wire logic [CTS_NUM_SUB-1:0] sub_compare0_i,
    input  wire logic [CTS_NUM_SUB-1:0] sub_compare1_i,
    input  wire logic [CTS_NUM_SUB-1:0] sub_channel0_output_i,
    // Capture request
    output var  logic                   capture0_o
);

    // ****************************************
    // Declarations
    // ****************************************
    logic                   addr_match;
    logic                   wr_hit;
    logic                   rd_hit;
    logic                   soft_en;
    logic                   update_en;
    logic [CTS_NUM_EXT-1:0] ext_en;
    logic [CTS_NUM_SUB-1:0] writable;
    logic [CTS_NUM_SUB-1:0] cmp1_en;
    logic [CTS_NUM_SUB-1:0] cmp0_en;
    logic [CTS_NUM_SUB-1:0] fall_en;
    logic [CTS_NUM_SUB-1:0] rise_en;
    logic [CTS_NUM_SUB-1:0] out_prev;
    logic [CTS_NUM_SUB-1:0] out_rise;
    logic [CTS_NUM_SUB-1:0] out_fall;
    logic [CTS_NUM_SUB-1:0] cmp1_hit;
    logic [CTS_NUM_SUB-1:0] cmp0_hit;
    logic [CTS_NUM_SUB-1:0] fall_hit;
    logic [CTS_NUM_SUB-1:0] rise_hit;
    logic [CTS_NUM_SUB-1:0] sub_hit;
    logic [CTS_NUM_EXT-1:0] ext_hit;
    logic                   any_sub;
    logic                   any_ext;
    logic                   update_hit;
    logic                   soft_hit;
    logic [31:0]            trig_sel;
    logic                   next_capture;

    // ****************************************
    // Address decode
    // ****************************************
    // Only the full word at the one offset is decoded
    assign addr_match = (reg_addr_i == CTS_ADDR_TRIG_SEL);
    assign wr_hit     = reg_wr_i && addr_match;
    assign rd_hit     = reg_rd_i && addr_match;

    // ****************************************
    // Software trigger bit
    // ****************************************
    // Write wins over the self-clear when both fall in one cycle
    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_n_i)
            soft_en <= CTS_TRIG_SEL_RESET[CTS_BIT_SOFT];
        else if (clk_en_i)
        begin
            if (wr_hit)
                soft_en <= reg_wdata_i[CTS_BIT_SOFT];
            else
                soft_en <= 1'b0;
        end
    end

    // ****************************************
    // Update event enable
    // ****************************************
    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_n_i)
            update_en <= CTS_TRIG_SEL_RESET[CTS_BIT_UPDATE];
        else if (clk_en_i && wr_hit)
            update_en <= reg_wdata_i[CTS_BIT_UPDATE];
    end

    // ****************************************
    // External event enables
    // ****************************************
    // Events arrive on this clock already, so no synchroniser
    genvar e;
    generate
        for (e = 0; e < CTS_NUM_EXT; e++)
        begin : gen_ext
            logic ext_bit;
            always_ff @(posedge ref_clk_i)
            begin
                if (!rst_n_i)
                    ext_bit <= CTS_TRIG_SEL_RESET[CTS_BIT_EXT_LO + e];
                else if (clk_en_i && wr_hit)
                    ext_bit <= reg_wdata_i[CTS_BIT_EXT_LO + e];
            end
            assign ext_en[e]  = ext_bit;
            assign ext_hit[e] = ext_bit && ext_event_i[e];
        end
    endgenerate

    // ****************************************
    // Self group
    // ****************************************
    // Own group never takes a one, so a stray write cannot enable it
    genvar s;
    generate
        for (s = 0; s < CTS_NUM_SUB; s++)
        begin : gen_self
            assign writable[s] = (s != SELF_INDEX);
        end
    endgenerate

    // ****************************************
    // Sibling group enables
    // ****************************************
    genvar g;
    generate
        for (g = 0; g < CTS_NUM_SUB; g++)
        begin : gen_sub
            localparam int B = CTS_SUB_BASE + CTS_SUB_GROUP*g;
            logic cmp1_bit;
            logic cmp0_bit;
            logic fall_bit;
            logic rise_bit;

            always_ff @(posedge ref_clk_i)
            begin
                if (!rst_n_i)
                    cmp1_bit <= CTS_TRIG_SEL_RESET[B+CTS_OFS_CMP1];
                else if (clk_en_i && wr_hit)
                    cmp1_bit <= writable[g] && reg_wdata_i[B+CTS_OFS_CMP1];
            end

            always_ff @(posedge ref_clk_i)
            begin
                if (!rst_n_i)
                    cmp0_bit <= CTS_TRIG_SEL_RESET[B+CTS_OFS_CMP0];
                else if (clk_en_i && wr_hit)
                    cmp0_bit <= writable[g] && reg_wdata_i[B+CTS_OFS_CMP0];
            end

            always_ff @(posedge ref_clk_i)
            begin
                if (!rst_n_i)
                    fall_bit <= CTS_TRIG_SEL_RESET[B+CTS_OFS_FALL];
                else if (clk_en_i && wr_hit)
                    fall_bit <= writable[g] && reg_wdata_i[B+CTS_OFS_FALL];
            end

            always_ff @(posedge ref_clk_i)
            begin
                if (!rst_n_i)
                    rise_bit <= CTS_TRIG_SEL_RESET[B+CTS_OFS_RISE];
                else if (clk_en_i && wr_hit)
                    rise_bit <= writable[g] && reg_wdata_i[B+CTS_OFS_RISE];
            end
            assign cmp1_en[g] = cmp1_bit;
            assign cmp0_en[g] = cmp0_bit;
            assign fall_en[g] = fall_bit;
            assign rise_en[g] = rise_bit;
        end
    endgenerate

    // ****************************************
    // Channel output edges
    // ****************************************
    // History starts inactive, so an output high after reset reads as a rise
    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_n_i)
            out_prev <= '0;
        else if (clk_en_i)
            out_prev <= sub_channel0_output_i;
    end

    genvar o;
    generate
        for (o = 0; o < CTS_NUM_SUB; o++)
        begin : gen_edge
            assign out_rise[o] = !out_prev[o] && sub_channel0_output_i[o];
            assign out_fall[o] = out_prev[o] && !sub_channel0_output_i[o];
        end
    endgenerate

    // ****************************************
    // Read-back word
    // ****************************************
    always_comb
    begin
        trig_sel = CTS_TRIG_SEL_RESET;
        trig_sel[CTS_BIT_SOFT] = soft_en;
        trig_sel[CTS_BIT_UPDATE] = update_en;
        trig_sel[CTS_BIT_EXT_LO +: CTS_NUM_EXT] = ext_en;
        for (int k = 0; k < CTS_NUM_SUB; k++)
        begin
            trig_sel[CTS_SUB_BASE + CTS_SUB_GROUP*k + CTS_OFS_CMP1] = cmp1_en[k];
            trig_sel[CTS_SUB_BASE + CTS_SUB_GROUP*k + CTS_OFS_CMP0] = cmp0_en[k];
            trig_sel[CTS_SUB_BASE + CTS_SUB_GROUP*k + CTS_OFS_FALL] = fall_en[k];
            trig_sel[CTS_SUB_BASE + CTS_SUB_GROUP*k + CTS_OFS_RISE] = rise_en[k];
        end
    end

    // ****************************************
    // Read data register
    // ****************************************
    // Data stands one cycle after the strobe, zero otherwise
    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_n_i)
            reg_rdata_o <= CTS_RDATA_NONE;
        else if (clk_en_i)
        begin
            if (rd_hit)
                reg_rdata_o <= trig_sel;
            else
                reg_rdata_o <= CTS_RDATA_NONE;
        end
    end

    // ****************************************
    // Sibling sources
    // ****************************************
    genvar h;
    generate
        for (h = 0; h < CTS_NUM_SUB; h++)
        begin : gen_hit
            assign cmp1_hit[h] = cmp1_en[h] && sub_compare1_i[h];
            assign cmp0_hit[h] = cmp0_en[h] && sub_compare0_i[h];
            assign fall_hit[h] = fall_en[h] && out_fall[h];
            assign rise_hit[h] = rise_en[h] && out_rise[h];
        end
    endgenerate
    assign sub_hit = cmp1_hit | cmp0_hit | fall_hit | rise_hit;
    assign any_sub = |sub_hit;

    // ****************************************
    // Local sources
    // ****************************************
    assign any_ext    = |ext_hit;
    assign update_hit = update_en && update_event_i;
    // Fires from the write itself; the stored bit only shows on read-back
    assign soft_hit   = wr_hit && reg_wdata_i[CTS_BIT_SOFT];

    // ****************************************
    // Capture combine
    // ****************************************
    // One pulse per cycle however many sources agree
    always_comb
    begin
        next_capture = 1'b0;
        if (any_sub)
            next_capture = 1'b1;
        if (any_ext)
            next_capture = 1'b1;
        if (update_hit)
            next_capture = 1'b1;
        if (soft_hit)
            next_capture = 1'b1;
    end

    // ****************************************
    // Capture register
    // ****************************************
    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_n_i)
            capture0_o <= 1'b0;
        else if (clk_en_i)
            capture0_o <= next_capture;
    end

endmodule

`default_nettype wire

// ==== test/cts_src.sv ====
// Event source model for siblings and external events
`timescale 1ns/10ps
`default_nettype none
module cts_src
(
    input  wire logic        clk_i,
    input  wire logic [25:0] req_i,
    output var  logic [25:0] evt_o
);
    always_ff @(posedge clk_i) evt_o <= req_i;
endmodule
`default_nettype wire

// ==== test/cts_sel_asserts.sv ====
// Assertions for the capture 0 trigger selector
`timescale 1ns/10ps
`default_nettype none
module cts_sel_asserts import cts_pkg::*; #(parameter int SELF_INDEX = 0) (
    input wire logic ref_clk_i, rst_n_i, clk_en_i, reg_wr_i, reg_rd_i, update_event_i, capture0_o,
    input wire logic [7:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i, reg_rdata_o,
    input wire logic [9:0] ext_event_i,
    input wire logic [4:0] sub_compare0_i, sub_compare1_i, sub_channel0_output_i);
    logic [31:0] r, t;
    logic [31:12] s;
    logic [4:0] p;
    wire logic h = clk_en_i && reg_addr_i == CTS_ADDR_TRIG_SEL;
    wire logic w = h && reg_wr_i && reg_wdata_i[0];
    always_ff @(posedge ref_clk_i)
        if (!rst_n_i) {r, p} <= '0;
        else if (clk_en_i) {r, p} <= {h && reg_wr_i ? reg_wdata_i & ~(32'hF << 12 + 4 * SELF_INDEX)
            : r & ~32'h1, sub_channel0_output_i};
    always_comb
        for (int g = 0; g < 5; g++)
            s[12 + 4 * g +: 4] = {sub_compare1_i[g], sub_compare0_i[g],
                p[g] & ~sub_channel0_output_i[g], ~p[g] & sub_channel0_output_i[g]};
    assign t = {s, ext_event_i, update_event_i, 1'b1} & r & {32{clk_en_i}};
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);
    sw_fire_a: assert property (w |=> capture0_o) else $error("soft miss");
    ext_fire_a: assert property (|t[11:2] |=> capture0_o) else $error("ext miss");
    upd_fire_a: assert property (t[1] |=> capture0_o) else $error("upd miss");
    cmp_fire_a: assert property (|(t & 32'hCCCC_C000) |=> capture0_o) else $error("cmp miss");
    fall_fire_a: assert property (|(t & 32'h2222_2000) |=> capture0_o) else $error("fall miss");
    rise_fire_a: assert property (|(t & 32'h1111_1000) |=> capture0_o) else $error("rise miss");
    quiet_cap_a: assert property (clk_en_i && !w && t == 0 |=> !capture0_o) else $error("spurious");
    rd_data_a: assert property (h && reg_rd_i |=> reg_rdata_o == $past(r)) else $error("rdata");
endmodule
bind cts_capture0_trigger_select cts_sel_asserts #(.SELF_INDEX(SELF_INDEX)) chk (.*);
`default_nettype wire

// ==== test/testbench.sv ====
// Bench for the capture 0 trigger selector
`timescale 1ns/10ps
`default_nettype none
module testbench import cts_pkg::*;;
    logic clk = 0, rst_n = 0, wr = 0, rd = 0, cap;
    logic [7:0] addr = 0;
    logic [31:0] wd = 0, rdat;
    logic [25:0] req = 0, evt;
    int miscompares = 0, samples_checked = 0;
    initial forever #4 clk = ~clk;
    initial #20000 results(1);
    cts_src src (.clk_i(clk), .req_i(req), .evt_o(evt));
    cts_capture0_trigger_select #(.SELF_INDEX(1)) dut (.ref_clk_i(clk), .rst_n_i(rst_n),
        .clk_en_i(1'b1), .reg_addr_i(addr), .reg_wdata_i(wd), .reg_wr_i(wr), .reg_rd_i(rd),
        .reg_rdata_o(rdat), .ext_event_i(evt[25:16]), .update_event_i(evt[15]),
        .sub_compare0_i(evt[14:10]), .sub_compare1_i(evt[9:5]),
        .sub_channel0_output_i(evt[4:0]), .capture0_o(cap));
    task automatic chk(input logic [31:0] got, exp);
        samples_checked++;
        miscompares += (got !== exp);
        if (got !== exp) $display("ERROR %0t got %h", $time, got);
    endtask
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk) {wr, rd, addr, wd} <= {w, !w, a, d};
        @(posedge clk) {wr, rd} <= 2'b00;
        #1;
    endtask
    task automatic fire(input int i, input logic e);
        @(posedge clk) req[i] <= 1'b1;
        @(posedge clk) req <= '0;
        @(posedge clk) #1 chk(cap, e);
        @(posedge clk) #1 chk(cap, e && i < 5);
        repeat (2) @(posedge clk);
    endtask
    task automatic results(input int late);
        miscompares += late;
        $display("checked %0d errors %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial
    begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        acc(0, CTS_ADDR_TRIG_SEL, 0);
        chk(rdat, CTS_TRIG_SEL_RESET);
        acc(1, CTS_ADDR_TRIG_SEL, 32'hFFF0_FFFF);
        chk(cap, 1);
        acc(0, CTS_ADDR_TRIG_SEL, 0);
        chk(rdat, 32'hFFF0_FFFE);
        acc(0, 8'h58, 0);
        chk(rdat, CTS_RDATA_NONE);
        for (int i = 0; i < 26; i++) fire(i, i % 5 != 1 || i > 14);
        acc(1, CTS_ADDR_TRIG_SEL, 0);
        for (int i = 0; i < 26; i++) fire(i, 0);
        results(0);
    end
endmodule
`default_nettype wire
